// >>> src/spa_split_alu.sv
// Split three-input ALU with lane carry flags, flag expansion and sign-conditional selection.
// Overview of operation
// - Signed add picks alt1 if last negative
// - Parallel store picks src1 if last negative
// - Carry saving writes lane carries into flags
// - Subtract carry means first lane not below
// - Status 0x24 selects byte ALU and expansion
// - Flag expands to lane ones, inverted complement
// - Mask as third input merges X/Y lanes
// - Any Boolean of operands in one cycle
// - Add carry flags lane unsigned overflow
// - Byte lanes: four independent carry chains
// - Byte, halfword, word sizes for both
// - Expansion size in status bits 5..3
// - Flag write beats flag rotation
// - Status 0x4 selects byte ALU only
module spa_split_alu (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       reqValid,
    input  wire spa_pkg::spa_req_s          req,
    input  wire logic                       storeReq,
    input  wire spa_pkg::spa_store_s        storeSrc,
    input  wire logic                       statusWe,
    input  wire logic [7:0]                 statusData,
    input  wire logic                       flagWe,
    input  wire logic [spa_pkg::DW-1:0]     flagData,
    output      logic [spa_pkg::DW-1:0]     result,
    output      logic                       resultValid,
    output      logic                       resultNegative,
    output      logic [spa_pkg::DW-1:0]     storeData,
    output      logic                       storeValid,
    output      logic [spa_pkg::DW-1:0]     laneFlags,
    output      logic [7:0]                 coreStatus
);
    localparam int DW = spa_pkg::DW;
    localparam int BW = spa_pkg::BW;

    logic [2:0]    aluSize;
    logic [2:0]    expSize;
    logic          rotEnable;
    logic [2:0]    aluLanes;
    logic [2:0]    expLanes;
    logic          negPrev;
    logic          isSub;
    logic          isArith;
    logic [DW-1:0] opB;
    logic [DW-1:0] addB;
    logic [DW-1:0] sum;
    logic [spa_pkg::BYTES-1:0] byteCarry;
    logic [spa_pkg::BYTES-1:0] laneStart;
    logic [3:0]    laneCarries;
    logic [DW-1:0] rotFlags;
    logic [DW-1:0] mask;
    logic [DW-1:0] maskZ;
    logic [DW-1:0] boolOut;

    logic [DW-1:0] next_result;
    logic          next_resultValid;
    logic          next_resultNegative;
    logic [DW-1:0] next_storeData;
    logic          next_storeValid;
    logic [DW-1:0] next_laneFlags;
    logic [7:0]    next_coreStatus;

    assign aluSize   = coreStatus[spa_pkg::ALU_SZ_HI:spa_pkg::ALU_SZ_LO];
    assign expSize   = coreStatus[spa_pkg::EXP_SZ_HI:spa_pkg::EXP_SZ_LO];
    assign rotEnable = coreStatus[spa_pkg::ROT_BIT];
    assign negPrev   = resultNegative;

    // Lane counts per size field; anything else acts as one word lane
    always_comb begin
        case (aluSize)
            spa_pkg::LANE_BYTE: aluLanes = spa_pkg::NLANE_BYTE;
            spa_pkg::LANE_HALF: aluLanes = spa_pkg::NLANE_HALF;
            default:            aluLanes = spa_pkg::NLANE_WORD;
        endcase
        case (expSize)
            spa_pkg::LANE_BYTE: expLanes = spa_pkg::NLANE_BYTE;
            spa_pkg::LANE_HALF: expLanes = spa_pkg::NLANE_HALF;
            default:            expLanes = spa_pkg::NLANE_WORD;
        endcase
    end

    assign isSub   = (req.op == spa_pkg::SPA_OP_SUB);
    assign isArith = (req.op != spa_pkg::SPA_OP_BOOL);
    assign opB     = (req.op == spa_pkg::SPA_OP_SIGNADD) ? (negPrev ? req.alt1 : req.alt2) : req.y;
    assign addB    = isSub ? ~opB : opB;

    // A lane boundary starts a fresh carry chain
    always_comb begin
        laneStart    = '0;
        laneStart[0] = 1'b1;
        laneStart[2] = (aluLanes != spa_pkg::NLANE_WORD);
        laneStart[1] = (aluLanes == spa_pkg::NLANE_BYTE);
        laneStart[3] = (aluLanes == spa_pkg::NLANE_BYTE);
    end

    genvar gb;
    generate
        for (gb = 0; gb < spa_pkg::BYTES; gb++) begin : g_byte
            logic       cin;
            logic [BW:0] part;
            if (gb == 0) begin : g_first
                assign cin = isSub;
            end else begin : g_rest
                assign cin = laneStart[gb] ? isSub : byteCarry[gb-1];
            end
            assign part = {1'b0, req.x[gb*BW +: BW]} + {1'b0, addB[gb*BW +: BW]} + {{BW{1'b0}}, cin};
            assign sum[gb*BW +: BW] = part[BW-1:0];
            assign byteCarry[gb]    = part[BW];
        end
    endgenerate

    // Carry of the top byte of each lane, packed from lane 0 upward
    always_comb begin
        case (aluLanes)
            spa_pkg::NLANE_BYTE: laneCarries = byteCarry;
            spa_pkg::NLANE_HALF: laneCarries = {2'b00, byteCarry[3], byteCarry[1]};
            default:             laneCarries = {3'b000, byteCarry[3]};
        endcase
    end

    // Flags rotate left by the lane count, taking expander input from the top
    always_comb begin
        case (expLanes)
            spa_pkg::NLANE_BYTE: rotFlags = {laneFlags[DW-5:0], laneFlags[DW-1:DW-4]};
            spa_pkg::NLANE_HALF: rotFlags = {laneFlags[DW-3:0], laneFlags[DW-1:DW-2]};
            default:             rotFlags = {laneFlags[DW-2:0], laneFlags[DW-1]};
        endcase
    end

    generate
        for (gb = 0; gb < spa_pkg::BYTES; gb++) begin : g_mask
            logic fb;
            always_comb begin
                case (expLanes)
                    spa_pkg::NLANE_BYTE: fb = rotEnable ? laneFlags[DW-4+gb] : laneFlags[gb];
                    spa_pkg::NLANE_HALF: fb = rotEnable ? laneFlags[DW-2+gb/2] : laneFlags[gb/2];
                    default:             fb = rotEnable ? laneFlags[DW-1] : laneFlags[0];
                endcase
            end
            assign mask[gb*BW +: BW] = {BW{fb}};
        end
    endgenerate

    assign maskZ = req.useMask ? (req.invMask ? ~mask : mask) : req.z;

    generate
        for (gb = 0; gb < DW; gb++) begin : g_bool
            assign boolOut[gb] = req.boolFn[{req.x[gb], req.y[gb], maskZ[gb]}];
        end
    endgenerate

    // Result group: value and sign hold between instructions for the next sign choice
    always_comb begin
        next_result         = result;
        next_resultNegative = resultNegative;
        next_resultValid    = reqValid;
        if (reqValid) begin
            next_result         = isArith ? sum : boolOut;
            next_resultNegative = next_result[DW-1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result         <= spa_pkg::RESULT_RESET;
            resultValid    <= 1'b0;
            resultNegative <= 1'b0;
        end else begin
            result         <= next_result;
            resultValid    <= next_resultValid;
            resultNegative <= next_resultNegative;
        end
    end

    // Store group: the source choice uses the sign from before this edge
    always_comb begin
        next_storeValid = storeReq;
        next_storeData  = storeReq ? (negPrev ? storeSrc.src1 : storeSrc.src2) : storeData;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            storeData  <= spa_pkg::RESULT_RESET;
            storeValid <= 1'b0;
        end else begin
            storeData  <= next_storeData;
            storeValid <= next_storeValid;
        end
    end

    // Status group: a load takes effect for the instruction after it
    always_comb begin
        next_coreStatus = statusWe ? statusData : coreStatus;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreStatus <= spa_pkg::STATUS_RESET;
        end else begin
            coreStatus <= next_coreStatus;
        end
    end

    // Flag group: rotation first, carry save over the low flags, a write over both
    always_comb begin
        next_laneFlags = laneFlags;
        if (reqValid && req.rotateFlags && rotEnable && req.useMask) begin
            next_laneFlags = rotFlags;
        end
        if (reqValid && isArith && req.saveCarries) begin
            case (aluLanes)
                spa_pkg::NLANE_BYTE: next_laneFlags[3:0] = laneCarries;
                spa_pkg::NLANE_HALF: next_laneFlags[1:0] = laneCarries[1:0];
                default:             next_laneFlags[0]   = laneCarries[0];
            endcase
        end
        if (flagWe) begin
            next_laneFlags = flagData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            laneFlags <= spa_pkg::FLAGS_RESET;
        end else begin
            laneFlags <= next_laneFlags;
        end
    end
endmodule : spa_split_alu

// >>> pkg/spa_pkg.sv
// Package for the split ALU: status layout, lane codes, opcodes and request carriers.
package spa_pkg;
    localparam int DW          = 32;
    localparam int BYTES       = 4;
    localparam int BW          = 8;
    // Status register layout
    localparam int ALU_SZ_LO   = 0;
    localparam int ALU_SZ_HI   = 2;
    localparam int EXP_SZ_LO   = 3;
    localparam int EXP_SZ_HI   = 5;
    localparam int ROT_BIT     = 6;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Lane size codes, used in both size fields
    localparam logic [2:0] LANE_BYTE = 3'h4;
    localparam logic [2:0] LANE_HALF = 3'h5;
    // Lane counts per size
    localparam logic [2:0] NLANE_BYTE = 3'h4;
    localparam logic [2:0] NLANE_HALF = 3'h2;
    localparam logic [2:0] NLANE_WORD = 3'h1;
    localparam logic [DW-1:0] FLAGS_RESET  = 32'h0000_0000;
    localparam logic [DW-1:0] RESULT_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        SPA_OP_BOOL    = 2'h0,
        SPA_OP_ADD     = 2'h1,
        SPA_OP_SUB     = 2'h3,
        SPA_OP_SIGNADD = 2'h2
    } spa_op_e;

    typedef struct packed {
        spa_op_e         op;
        logic [DW-1:0]   x;
        logic [DW-1:0]   y;
        logic [DW-1:0]   z;
        logic [DW-1:0]   alt1;
        logic [DW-1:0]   alt2;
        logic [7:0]      boolFn;
        logic            useMask;
        logic            invMask;
        logic            saveCarries;
        logic            rotateFlags;
    } spa_req_s;

    typedef struct packed {
        logic [DW-1:0]   src1;
        logic [DW-1:0]   src2;
    } spa_store_s;
endpackage : spa_pkg

// >>> tb/spa_split_alu_assertions.sv
// Port-level concurrent checks for the split ALU.
module spa_split_alu_assertions (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   reqValid,
    input wire spa_pkg::spa_req_s      req,
    input wire logic                   storeReq,
    input wire spa_pkg::spa_store_s    storeSrc,
    input wire logic                   statusWe,
    input wire logic [7:0]             statusData,
    input wire logic                   flagWe,
    input wire logic [spa_pkg::DW-1:0] flagData,
    input wire logic [spa_pkg::DW-1:0] result,
    input wire logic                   resultValid,
    input wire logic                   resultNegative,
    input wire logic [spa_pkg::DW-1:0] storeData,
    input wire logic                   storeValid,
    input wire logic [spa_pkg::DW-1:0] laneFlags,
    input wire logic [7:0]             coreStatus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [spa_pkg::DW-1:0] sumSel;
    always_comb sumSel = req.x + (resultNegative ? req.alt1 : req.alt2);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_result_valid: assert property (reqValid |=> resultValid) else $error("result valid missing");
    a_store_pick: assert property (storeReq |=> storeValid && storeData == ($past(resultNegative) ?
        $past(storeSrc.src1) : $past(storeSrc.src2))) else $error("store source wrong");
    a_store_quiet: assert property (!storeReq |=> !storeValid) else $error("spurious store");
    a_signadd_pick: assert property (reqValid && req.op == spa_pkg::SPA_OP_SIGNADD && coreStatus == 8'h00
        |=> result == $past(sumSel)) else $error("sign add operand wrong");
    a_flag_write: assert property (flagWe |=> laneFlags == $past(flagData)) else $error("flag write lost");
    a_flag_hold: assert property (!flagWe && !(reqValid && (req.saveCarries || req.rotateFlags))
        |=> $stable(laneFlags)) else $error("flags changed");
    a_status_load: assert property (statusWe |=> coreStatus == $past(statusData)) else $error("status load");
    a_neg_sign: assert property (resultValid |-> resultNegative == result[31]) else $error("sign flag wrong");
    a_mask_merge: assert property (reqValid && req.op == spa_pkg::SPA_OP_BOOL && req.boolFn == 8'hE4
        && req.useMask && !req.invMask && coreStatus == 8'h00
        |=> result == ($past(laneFlags[0]) ? $past(req.x) : $past(req.y))) else $error("merge wrong");
endmodule : spa_split_alu_assertions

// >>> tb/test_spa_split_alu.sv
// Directed bench for the split ALU.
module test_spa_split_alu;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, storeReq = 1'b0, statusWe = 1'b0, flagWe = 1'b0;
    spa_pkg::spa_req_s   r  = '0;
    spa_pkg::spa_store_s ss = '0;
    logic [7:0]  sd = 8'h00, coreStatus;
    logic [31:0] fd = 32'h0000_0000, result, storeData, laneFlags;
    logic        resultValid, resultNegative, storeValid;
    logic [7:0]  fns [6] = '{8'h00, 8'h96, 8'h80, 8'hFE, 8'hE8, 8'hFF};
    int          fails = 0, n_compared = 0;
    // Truth table of z ? x : y, indexed {x, y, z}
    localparam logic [7:0] MERGE = 8'hE4;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
    always #4 clk = ~clk;
    spa_split_alu i_dut (.clk(clk), .rst(rst), .reqValid(reqValid), .req(r), .storeReq(storeReq), .storeSrc(ss),
        .statusWe(statusWe), .statusData(sd), .flagWe(flagWe), .flagData(fd), .result(result),
        .resultValid(resultValid), .resultNegative(resultNegative), .storeData(storeData),
        .storeValid(storeValid), .laneFlags(laneFlags), .coreStatus(coreStatus));
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic go(input logic st);
        reqValid = 1'b1;
        storeReq = st;
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        storeReq = 1'b0;
        flagWe = 1'b0;
        `CHK("valid", 1'b1, resultValid)
        `CHK("store valid", st, storeValid)
        @(posedge clk);
        #1;
        `CHK("valid drop", 1'b0, resultValid)
    endtask : go
    task automatic ws(input logic [7:0] v);
        sd = v;
        statusWe = 1'b1;
        @(posedge clk);
        #1;
        statusWe = 1'b0;
        `CHK("status", v, coreStatus)
    endtask : ws
    task automatic op(input spa_pkg::spa_op_e o, input logic [31:0] x, input logic [31:0] y, input logic sv);
        r = '0;
        r.op = o;
        r.x = x;
        r.y = y;
        r.saveCarries = sv;
        go(1'b0);
    endtask : op
    task automatic mrg(input logic [31:0] x, input logic [31:0] y, input logic inv);
        r = '0;
        r.x = x;
        r.y = y;
        r.boolFn = MERGE;
        r.useMask = 1'b1;
        r.invMask = inv;
        go(1'b0);
    endtask : mrg
    initial begin
        #20000;
        fails++;
        test_done;
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        ws(8'h24);
        op(spa_pkg::SPA_OP_SUB, 32'hD064_2889, 32'hA37A_2D4E, 1'b1);
        `CHK("sub", 32'h2DEA_FB3B, result)
        `CHK("subflags", 4'h9, laneFlags[3:0])
        mrg(32'hD064_2889, 32'hA37A_2D4E, 1'b0);
        `CHK("max", 32'hD07A_2D89, result)
        mrg(32'hD064_2889, 32'hA37A_2D4E, 1'b1);
        `CHK("min", 32'hA364_284E, result)
        op(spa_pkg::SPA_OP_ADD, 32'hFF64_C81E, 32'h017A_6432, 1'b1);
        `CHK("add", 32'h00DE_2C50, result)
        `CHK("addflags", 4'hA, laneFlags[3:0])
        $display("test byte lanes done");
        ws(8'h04);
        op(spa_pkg::SPA_OP_ADD, 32'hFF64_C81E, 32'h017A_6432, 1'b0);
        `CHK("byteonly", 32'h00DE_2C50, result)
        `CHK("keepflags", 4'hA, laneFlags[3:0])
        ws(8'h2D);
        op(spa_pkg::SPA_OP_ADD, 32'hFFFF_0001, 32'h0001_0001, 1'b1);
        `CHK("half", 32'h0000_0002, result)
        `CHK("halfflags", 2'h2, laneFlags[1:0])
        mrg(32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
        `CHK("halfmask", 32'hFFFF_0000, result)
        ws(8'h00);
        op(spa_pkg::SPA_OP_ADD, 32'hFFFF_FFFF, 32'h0000_0001, 1'b1);
        `CHK("word", 32'h0000_0000, result)
        `CHK("wordflag", 1'b1, laneFlags[0])
        mrg(32'hAAAA_AAAA, 32'h5555_5555, 1'b0);
        `CHK("wordmask", 32'hAAAA_AAAA, result)
        mrg(32'hAAAA_AAAA, 32'h5555_5555, 1'b1);
        `CHK("wordinv", 32'h5555_5555, result)
        $display("test lane sizes done");
        r = '0;
        r.x = 32'hF0F0_F0F0;
        r.y = 32'hCCCC_CCCC;
        r.z = 32'hAAAA_AAAA;
        for (int k = 0; k < 6; k++) begin
            r.boolFn = fns[k];
            go(1'b0);
            `CHK("bool", {4{fns[k]}}, result)
        end
        r = '0;
        r.op = spa_pkg::SPA_OP_SIGNADD;
        r.x = 32'h0000_0010;
        r.alt1 = 32'h0000_0001;
        r.alt2 = 32'h0000_0002;
        ss = {32'h0000_000A, 32'h0000_000B};
        go(1'b1);
        `CHK("signneg", 32'h0000_0011, result)
        `CHK("storeneg", 32'h0000_000A, storeData)
        go(1'b1);
        `CHK("signpos", 32'h0000_0012, result)
        `CHK("storepos", 32'h0000_000B, storeData)
        $display("test bool and sign done");
        ws(8'h64);
        fd = 32'h1234_5678;
        flagWe = 1'b1;
        r = '0;
        r.x = 32'h8888_8888;
        r.y = 32'h3333_3333;
        r.boolFn = MERGE;
        r.useMask = 1'b1;
        r.rotateFlags = 1'b1;
        go(1'b0);
        `CHK("flagwin", 32'h1234_5678, laneFlags)
        `CHK("expand0", 32'h3333_3333, result)
        go(1'b0);
        `CHK("rotate", 32'h2345_6781, laneFlags)
        `CHK("expand1", 32'h3333_3388, result)
        go(1'b0);
        `CHK("expand2", 32'h3333_8833, result)
        $display("test flag rotation done");
        test_done;
    end
endmodule : test_spa_split_alu
bind spa_split_alu spa_split_alu_assertions u_chk (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
    .storeReq(storeReq), .storeSrc(storeSrc), .statusWe(statusWe), .statusData(statusData), .flagWe(flagWe),
    .flagData(flagData), .result(result), .resultValid(resultValid), .resultNegative(resultNegative),
    .storeData(storeData), .storeValid(storeValid), .laneFlags(laneFlags), .coreStatus(coreStatus));
